// file: nvss_host.sv
// Host controller driving the asynchronous pins of a nonvolatile shadow SRAM.
`timescale 1ns/10ps
module nvss_host #(
    parameter int STORE_CYC = nvss_pkg::STORE_BUSY_CYC,
    parameter int RECALL_CYC = nvss_pkg::RECALL_BUSY_CYC,
    parameter int RELOAD_CYC = nvss_pkg::RELOAD_CYC
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [1:0] cmd_op,
    input wire logic [nvss_pkg::ADDR_W-1:0] cmd_addr,
    input wire logic [nvss_pkg::DATA_W-1:0] cmd_wdata,
    output logic rsp_valid,
    output logic [nvss_pkg::DATA_W-1:0] rsp_rdata,
    input wire logic supply_ok,
    output logic [nvss_pkg::ADDR_W-1:0] mem_addr,
    output logic chip_en_n,
    output logic out_en_n,
    output logic wr_en_n,
    input wire logic [nvss_pkg::DATA_W-1:0] data_io_bus_i,
    output logic [nvss_pkg::DATA_W-1:0] data_io_bus_o,
    output logic data_io_bus_oe
);
    // ****************************************************************
    // States.
    // ****************************************************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_SETUP = 3'h1,
        ST_STROBE = 3'h3,
        ST_HOLD = 3'h2,
        ST_NEXT = 3'h6,
        ST_BUSY = 3'h7
    } nvss_state_t;

    localparam int CNT_W = 24;
    localparam logic [2:0] ACC_LAST = 3'(nvss_pkg::ACC_CYC - 1);
    localparam logic [2:0] SEQ_LAST = 3'(nvss_pkg::SEQ_LEN - 1);

    nvss_state_t state_r;
    logic [2:0] acc_cnt_r;
    logic [2:0] seq_idx_r;
    logic [1:0] op_r;
    logic is_seq_r;
    logic [nvss_pkg::DATA_W-1:0] wdata_r;
    logic sup_s1_r;
    logic sup_s2_r;
    logic sup_d_r;
    logic [nvss_pkg::DATA_W-1:0] din_s1_r;
    logic [nvss_pkg::DATA_W-1:0] din_s2_r;
    logic wait_start;
    logic [CNT_W-1:0] wait_count;
    logic busy;
    logic [nvss_pkg::SEQ_W-1:0] seq_addr;
    logic [2:0] seq_idx_nxt;
    logic sup_rise;

    // ****************************************************************
    // Synchronisers for supply status and read data.
    // ****************************************************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sup_s1_r <= 1'b0;
            sup_s2_r <= 1'b0;
            sup_d_r <= 1'b0;
            din_s1_r <= '0;
            din_s2_r <= '0;
        end else begin
            sup_s1_r <= supply_ok;
            sup_s2_r <= sup_s1_r;
            sup_d_r <= sup_s2_r;
            din_s1_r <= data_io_bus_i;
            din_s2_r <= din_s1_r;
        end
    end

    assign sup_rise = sup_s2_r && !sup_d_r;

    // ****************************************************************
    // Sequence address table.
    // ****************************************************************
    // The table gives the address of the access that follows the current one.
    assign seq_idx_nxt = seq_idx_r + 3'h1;

    always_comb begin
        case (seq_idx_nxt)
            3'h1: seq_addr = nvss_pkg::SEQ_A1;
            3'h2: seq_addr = nvss_pkg::SEQ_A2;
            3'h3: seq_addr = nvss_pkg::SEQ_A3;
            3'h4: seq_addr = nvss_pkg::SEQ_A4;
            3'h5: begin
                seq_addr = (op_r == nvss_pkg::CMD_STORE) ? nvss_pkg::SEQ_STORE
                                                         : nvss_pkg::SEQ_RECALL;
            end
            default: begin
                seq_addr = nvss_pkg::SEQ_A0;
            end
        endcase
    end

    // ****************************************************************
    // Busy timer for store, recall and power-up recall.
    // ****************************************************************
    always_comb begin
        wait_start = 1'b0;
        wait_count = CNT_W'(RELOAD_CYC);
        if (sup_rise) begin
            wait_start = 1'b1;
        end else if (state_r == ST_NEXT && is_seq_r && seq_idx_r == SEQ_LAST) begin
            wait_start = 1'b1;
            wait_count = (op_r == nvss_pkg::CMD_STORE) ? CNT_W'(STORE_CYC)
                                                       : CNT_W'(RECALL_CYC);
        end
    end

    nvss_wait #(.CNT_W(CNT_W)) u_wait (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .start(wait_start),
        .count(wait_count),
        .busy(busy)
    );

    // No command is taken while supply is low; a pending reload blocks every new command.
    assign cmd_ready = (state_r == ST_IDLE) && sup_s2_r && !busy && !sup_rise;

    // ****************************************************************
    // Access sequencer.
    // ****************************************************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            acc_cnt_r <= '0;
            seq_idx_r <= '0;
            op_r <= nvss_pkg::CMD_READ;
            is_seq_r <= 1'b0;
            wdata_r <= '0;
            mem_addr <= '0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    seq_idx_r <= '0;
                    if (cmd_valid && cmd_ready) begin
                        op_r <= cmd_op;
                        is_seq_r <= cmd_op[1];
                        wdata_r <= cmd_wdata;
                        if (cmd_op[1]) begin
                            mem_addr <= {1'b0, nvss_pkg::SEQ_A0};
                        end else begin
                            mem_addr <= cmd_addr;
                        end
                        state_r <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    acc_cnt_r <= '0;
                    state_r <= ST_STROBE;
                end
                ST_STROBE: begin
                    acc_cnt_r <= acc_cnt_r + 3'h1;
                    if (acc_cnt_r == ACC_LAST) begin
                        state_r <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    state_r <= ST_NEXT;
                end
                ST_NEXT: begin
                    if (is_seq_r && seq_idx_r != SEQ_LAST) begin
                        seq_idx_r <= seq_idx_nxt;
                        state_r <= ST_SETUP;
                    end else if (is_seq_r) begin
                        state_r <= ST_BUSY;
                    end else begin
                        state_r <= ST_IDLE;
                    end
                end
                ST_BUSY: begin
                    if (!busy) begin
                        state_r <= ST_IDLE;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
            if (state_r == ST_NEXT && is_seq_r && seq_idx_r != SEQ_LAST) begin
                mem_addr <= {1'b0, seq_addr};
            end
        end
    end

    // ****************************************************************
    // Pin drive and read capture.
    // ****************************************************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            chip_en_n <= 1'b1;
            out_en_n <= 1'b1;
            wr_en_n <= 1'b1;
            data_io_bus_o <= '0;
            data_io_bus_oe <= 1'b0;
        end else begin
            chip_en_n <= !(state_r == ST_SETUP || state_r == ST_STROBE);
            out_en_n <= !(state_r == ST_SETUP || state_r == ST_STROBE)
                        || op_r != nvss_pkg::CMD_READ;
            wr_en_n <= !((state_r == ST_SETUP || state_r == ST_STROBE)
                        && op_r == nvss_pkg::CMD_WRITE);
            data_io_bus_o <= wdata_r;
            data_io_bus_oe <= (state_r == ST_SETUP || state_r == ST_STROBE || state_r == ST_HOLD)
                              && op_r == nvss_pkg::CMD_WRITE;
        end
    end

    // Read data is taken after the synchroniser delay, two cycles past strobe end.
    logic rd_pipe_r;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_pipe_r <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
        end else begin
            rd_pipe_r <= state_r == ST_HOLD && op_r == nvss_pkg::CMD_READ;
            rsp_valid <= rd_pipe_r;
            if (rd_pipe_r) begin
                rsp_rdata <= din_s2_r;
            end
        end
    end

    // ****************************************************************
    // Assertions.
    // ****************************************************************
    property p_wr_oe_high;
        @(posedge clk_sys) disable iff (!rst_n)
        !wr_en_n |-> out_en_n;
    endproperty
    a_wr_oe_high: assert property (p_wr_oe_high) else $error("Output enable low during write.");

    property p_addr_stable;
        @(posedge clk_sys) disable iff (!rst_n)
        (!wr_en_n && !$past(wr_en_n)) |-> $stable(mem_addr);
    endproperty
    a_addr_stable: assert property (p_addr_stable) else $error("Address moved during write.");

    property p_seq_we_high;
        @(posedge clk_sys) disable iff (!rst_n)
        (is_seq_r && state_r != ST_IDLE) |-> wr_en_n;
    endproperty
    a_seq_we_high: assert property (p_seq_we_high) else $error("Write low in sequence.");

    property p_seq_first;
        @(posedge clk_sys) disable iff (!rst_n)
        (state_r == ST_SETUP && is_seq_r && seq_idx_r == 3'h0)
            |-> mem_addr[nvss_pkg::SEQ_W-1:0] == nvss_pkg::SEQ_A0;
    endproperty
    a_seq_first: assert property (p_seq_first) else $error("Bad first sequence address.");

    property p_seq_last;
        @(posedge clk_sys) disable iff (!rst_n)
        (state_r == ST_SETUP && is_seq_r && seq_idx_r == SEQ_LAST && op_r == nvss_pkg::CMD_RECALL)
            |-> mem_addr[nvss_pkg::SEQ_W-1:0] == nvss_pkg::SEQ_RECALL;
    endproperty
    a_seq_last: assert property (p_seq_last) else $error("Bad recall address.");

    property p_busy_idle;
        @(posedge clk_sys) disable iff (!rst_n)
        busy |-> ##1 chip_en_n;
    endproperty
    a_busy_idle: assert property (p_busy_idle) else $error("Access during busy time.");

    property p_no_store_low;
        @(posedge clk_sys) disable iff (!rst_n)
        !sup_s2_r |-> !cmd_ready;
    endproperty
    a_no_store_low: assert property (p_no_store_low) else $error("Command taken at low supply.");

    property p_recall_end;
        @(posedge clk_sys) disable iff (!rst_n)
        (wait_start && wait_count == CNT_W'(RECALL_CYC)) |-> ##1 busy;
    endproperty
    a_recall_end: assert property (p_recall_end) else $error("Recall wait not started.");
endmodule : nvss_host

// file: nvss_pkg.sv
// Package of constants for the nonvolatile shadow SRAM host controller.
package nvss_pkg;
    // ****************************************************************
    // Geometry and timing.
    // ****************************************************************
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int SEQ_W = 14;
    localparam int SEQ_LEN = 6;
    localparam int CLK_NS = 50;
    localparam int ACC_NS = 55;
    localparam int ACC_CYC = (ACC_NS + CLK_NS - 1) / CLK_NS + 1;
    localparam int STORE_BUSY_MS = 10;
    localparam int STORE_BUSY_CYC = (STORE_BUSY_MS * 1000000) / CLK_NS;
    localparam int RECALL_BUSY_US = 20;
    localparam int RECALL_BUSY_CYC = (RECALL_BUSY_US * 1000) / CLK_NS;
    localparam int RELOAD_US = 550;
    localparam int RELOAD_CYC = (RELOAD_US * 1000) / CLK_NS;
    // ****************************************************************
    // Software sequence addresses.
    // ****************************************************************
    localparam logic [SEQ_W-1:0] SEQ_A0 = 14'h0E38;
    localparam logic [SEQ_W-1:0] SEQ_A1 = 14'h31C7;
    localparam logic [SEQ_W-1:0] SEQ_A2 = 14'h03E0;
    localparam logic [SEQ_W-1:0] SEQ_A3 = 14'h3C1F;
    localparam logic [SEQ_W-1:0] SEQ_A4 = 14'h303F;
    localparam logic [SEQ_W-1:0] SEQ_STORE = 14'h0FC0;
    localparam logic [SEQ_W-1:0] SEQ_RECALL = 14'h0C63;
    // ****************************************************************
    // Commands.
    // ****************************************************************
    localparam logic [1:0] CMD_READ = 2'h0;
    localparam logic [1:0] CMD_WRITE = 2'h1;
    localparam logic [1:0] CMD_STORE = 2'h2;
    localparam logic [1:0] CMD_RECALL = 2'h3;
endpackage : nvss_pkg

// file: nvss_wait.sv
// Busy wait counter used after store, recall and power restore.
`timescale 1ns/10ps
module nvss_wait #(
    parameter int CNT_W = 24
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [CNT_W-1:0] count,
    output logic busy
);
    logic [CNT_W-1:0] cnt_r;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
        end else if (start) begin
            cnt_r <= count;
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
        end
    end

    assign busy = (cnt_r != '0);
endmodule : nvss_wait

// file: nvss_mem_model.sv
// Behavioural model of the nonvolatile shadow SRAM seen at the host pins.
`timescale 1ns/10ps
module nvss_mem_model #(
    parameter int STORE_NS = 2000,
    parameter int RECALL_NS = 800,
    parameter int RELOAD_NS = 800
) (
    input wire logic supply_ok,
    input wire logic [14:0] mem_addr,
    input wire logic chip_en_n,
    input wire logic out_en_n,
    input wire logic wr_en_n,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe
);
    logic [7:0] sram [0:32767];
    logic [7:0] nv [0:32767] = '{default: 8'h00};
    logic [13:0] seq [0:4] = '{nvss_pkg::SEQ_A0, nvss_pkg::SEQ_A1, nvss_pkg::SEQ_A2,
        nvss_pkg::SEQ_A3, nvss_pkg::SEQ_A4};
    logic busy = 1'h0;
    logic in_wr = 1'h0;
    logic pend = 1'h1;
    int step = 0;
    assign data_oe = !chip_en_n && !out_en_n && wr_en_n && !busy && supply_ok;
    assign data_out = sram[mem_addr];
    task automatic recall_op(input int dur);
        busy = 1'h1;
        foreach (sram[i]) sram[i] = 8'h00;
        #(dur);
        foreach (sram[i]) sram[i] = nv[i];
        busy = 1'h0;
    endtask : recall_op
    always @(negedge chip_en_n or negedge wr_en_n) begin
        // Both strobes may fall in one time step; the short wait lets both settle.
        #1;
        if (!chip_en_n && !wr_en_n && !busy) begin
            in_wr = 1'h1;
            step = 0;
        end
    end
    always @(posedge chip_en_n or posedge wr_en_n) begin
        if (in_wr && !busy) sram[mem_addr] = data_in;
        in_wr = 1'h0;
    end
    always @(negedge chip_en_n) begin
        logic [13:0] a;
        #1;
        a = mem_addr[13:0];
        if (wr_en_n === 1'h1 && !busy) begin
            if (step == 5) begin
                step = 0;
                if (a == nvss_pkg::SEQ_STORE && supply_ok) begin
                    busy = 1'h1;
                    foreach (nv[i]) nv[i] = 8'hFF;
                    #(STORE_NS);
                    foreach (nv[i]) nv[i] = sram[i];
                    busy = 1'h0;
                end
                if (a == nvss_pkg::SEQ_RECALL) recall_op(RECALL_NS);
            end else if (a == seq[step]) begin
                step++;
            end else begin
                step = (a == seq[0]) ? 1 : 0;
            end
        end
    end
    always @(supply_ok) begin
        if (supply_ok !== 1'h1) begin
            pend = 1'h1;
        end else if (pend) begin
            pend = 1'h0;
            recall_op(RELOAD_NS);
            if (!chip_en_n && !wr_en_n) foreach (sram[i]) sram[i] = 8'hXX;
        end
    end
endmodule : nvss_mem_model

// file: tb.sv
// Self-checking testbench of the host controller against the memory model.
`timescale 1ns/10ps
module tb;
    logic clk_sys = 1'h0;
    logic rst_n = 1'h0;
    logic cmd_valid = 1'h0;
    logic [1:0] cmd_op = 2'h0;
    logic [14:0] cmd_addr = 15'h0000;
    logic [7:0] cmd_wdata = 8'h00;
    logic supply_ok = 1'h0;
    logic cmd_ready;
    logic rsp_valid;
    logic [7:0] rsp_rdata;
    logic [14:0] mem_addr;
    logic chip_en_n;
    logic out_en_n;
    logic wr_en_n;
    logic [7:0] host_o;
    logic host_oe;
    logic [7:0] dev_o;
    logic dev_oe;
    logic [7:0] float_r = 8'h5A;
    logic [7:0] data_wire;
    logic [14:0] last_addr = 15'h0000;
    logic prev_wr = 1'h0;
    int num_errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    assign data_wire = host_oe ? host_o : (dev_oe ? dev_o : float_r);
    initial begin
        forever #25 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) float_r <= ~float_r;
    nvss_host #(.STORE_CYC(50), .RECALL_CYC(20), .RELOAD_CYC(20)) dut_u (
        .clk_sys(clk_sys), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .supply_ok(supply_ok), .mem_addr(mem_addr),
        .chip_en_n(chip_en_n), .out_en_n(out_en_n), .wr_en_n(wr_en_n),
        .data_io_bus_i(data_wire), .data_io_bus_o(host_o), .data_io_bus_oe(host_oe));
    nvss_mem_model mem_u (.supply_ok(supply_ok), .mem_addr(mem_addr), .chip_en_n(chip_en_n),
        .out_en_n(out_en_n), .wr_en_n(wr_en_n), .data_in(data_wire), .data_out(dev_o),
        .data_oe(dev_oe));
    task automatic test_done();
        $display("Counts: %0d compares, %0d mismatches", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : test_done
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s: expected %h, seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic do_cmd(input logic [1:0] op, input logic [14:0] a, input logic [7:0] d,
            output logic [7:0] q);
        int n;
        n = 0;
        q = 8'hXX;
        @(negedge clk_sys);
        cmd_valid = 1'h1;
        cmd_op = op;
        cmd_addr = a;
        cmd_wdata = d;
        while (cmd_ready !== 1'h1 && n < 2000) begin
            @(negedge clk_sys);
            n++;
        end
        chk("command ready", 16'h0001, {15'h0000, cmd_ready});
        @(negedge clk_sys);
        cmd_valid = 1'h0;
        if (op == nvss_pkg::CMD_READ) begin
            n = 0;
            while (rsp_valid !== 1'h1 && n < 40) begin
                @(negedge clk_sys);
                n++;
            end
            chk("read response", 16'h0001, {15'h0000, rsp_valid});
            q = rsp_rdata;
        end
    endtask : do_cmd
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        logic [7:0] q;
        do_cmd(nvss_pkg::CMD_WRITE, a, d, q);
    endtask : wr
    task automatic rd(input logic [14:0] a, input logic [7:0] d, input string nm);
        logic [7:0] q;
        do_cmd(nvss_pkg::CMD_READ, a, 8'h00, q);
        chk(nm, {8'h00, d}, {8'h00, q});
    endtask : rd
    task automatic t_rw();
        logic [14:0] a [0:4] = '{15'h0000, 15'h7FFF, 15'h4E38, 15'h0E38, 15'h1234};
        logic [7:0] d [0:4] = '{8'h96, 8'hB7, 8'h3C, 8'hC3, 8'h69};
        for (int i = 0; i < 5; i++) wr(a[i], d[i]);
        for (int i = 0; i < 5; i++) rd(a[i], d[i], "read back");
        $display("test rw done");
    endtask : t_rw
    task automatic t_sr();
        logic [7:0] q;
        wr(15'h0100, 8'h11);
        do_cmd(nvss_pkg::CMD_STORE, 15'h0000, 8'h00, q);
        rd(15'h0100, 8'h11, "sram after store");
        wr(15'h0100, 8'h22);
        rd(15'h0100, 8'h22, "sram rewritten");
        do_cmd(nvss_pkg::CMD_RECALL, 15'h0000, 8'h00, q);
        rd(15'h0100, 8'h11, "sram after recall");
        wr(15'h0100, 8'h44);
        do_cmd(nvss_pkg::CMD_RECALL, 15'h0000, 8'h00, q);
        rd(15'h0100, 8'h11, "second recall");
        rd(15'h4E38, 8'h3C, "upper half after recall");
        $display("test store recall done");
    endtask : t_sr
    task automatic t_power();
        int n;
        n = 0;
        wr(15'h0100, 8'h33);
        @(negedge clk_sys);
        supply_ok = 1'h0;
        repeat (10) @(negedge clk_sys);
        chk("ready at low supply", 16'h0000, {15'h0000, cmd_ready});
        supply_ok = 1'h1;
        while (cmd_ready !== 1'h1 && n < 100) begin
            @(negedge clk_sys);
            n++;
            chk("write strobe in reload", 16'h0001, {15'h0000, wr_en_n});
        end
        chk("reload wait in range", 16'h0001, {15'h0000, n >= 20 && n <= 26});
        rd(15'h0100, 8'h11, "sram after power restore");
        $display("test power done");
    endtask : t_power
    always @(negedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            test_done();
        end
        if (!chip_en_n && !wr_en_n) begin
            chk("write pins", 16'h0006, {13'h0000, out_en_n, host_oe, dev_oe});
            if (prev_wr) chk("write address", {1'h0, last_addr}, {1'h0, mem_addr});
        end
        prev_wr = !chip_en_n && !wr_en_n;
        last_addr = mem_addr;
    end
    initial begin
        repeat (6) @(negedge clk_sys);
        rst_n = 1'h1;
        supply_ok = 1'h1;
        t_rw();
        t_sr();
        t_power();
        test_done();
    end
endmodule : tb
